// file: pkg/css_pkg.sv
// Purpose: Shared constants and types for the clock source select block.
// Assumes: One 40 MHz system clock; source clocks are slower than clk/4.
// Notes:   Register offsets are page-zero byte addresses.
// Operation
// - Reference code picks MCLK, SCLK, oscillator, GPIO.
// - Auto-set mode overrides software reference choice.
// - Undefined reference codes mute the reference.
// - DSP source codes 000-101; others mute.
// - DAC source uses DSP encoding; others mute.
// - Oversampling source codes 000-110; others mute.
// - Charge-pump source uses oversampling encoding.
// - Master clock auto-picks PLL/MCLK path or oscillator.
// - DSP pin select: 011 zero, 101 two.
// - DAC pin select: 011 zero, 101 two.
// - Charge-pump pin select likewise; 010 mutes.
// - Oversampling pin select likewise; others mute.
// - DAC run low halts DAC and derived clocks.
// - Reference pin select: 011 zero, 101 two.
package css_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] CSS_OFF_REF_DSP  = 8'h0D;
   localparam logic [7:0] CSS_OFF_DAC_OVS  = 8'h0E;
   localparam logic [7:0] CSS_OFF_CP       = 8'h0F;
   localparam logic [7:0] CSS_OFF_PIN_DD   = 8'h10;
   localparam logic [7:0] CSS_OFF_PIN_CO   = 8'h11;
   localparam logic [7:0] CSS_OFF_PIN_REF  = 8'h12;

   // Field positions (low bit of each three-bit field)
   localparam int CSS_POS_HI = 4;
   localparam int CSS_POS_LO = 0;

   // Reset value of every select field
   localparam logic [2:0] CSS_FIELD_RST = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Source codes
   localparam logic [2:0] CSS_REF_MCLK       = 3'h0;
   localparam logic [2:0] CSS_REF_SCLK       = 3'h1;
   localparam logic [2:0] CSS_REF_OSCILLATOR = 3'h2;
   localparam logic [2:0] CSS_REF_GPIO       = 3'h3;
   localparam logic [2:0] CSS_CORE_LAST      = 3'h5;
   localparam logic [2:0] CSS_OVS_DAC        = 3'h0;
   localparam logic [2:0] CSS_OVS_LAST       = 3'h6;
   localparam logic [2:0] CSS_PIN_ZERO       = 3'h3;
   localparam logic [2:0] CSS_PIN_TWO        = 3'h5;

   // Positions in each channel's candidate vector
   localparam logic [2:0] CSS_IDX_MASTER     = 3'h0;
   localparam logic [2:0] CSS_IDX_PLL        = 3'h1;
   localparam logic [2:0] CSS_IDX_OSCILLATOR = 3'h2;
   localparam logic [2:0] CSS_IDX_MCLK       = 3'h3;
   localparam logic [2:0] CSS_IDX_SCLK       = 3'h4;
   localparam logic [2:0] CSS_IDX_GPIO       = 3'h5;
   localparam logic [2:0] CSS_IDX_DAC        = 3'h6;

   // Channel numbers
   localparam int CSS_CH_DSP = 0;
   localparam int CSS_CH_DAC = 1;
   localparam int CSS_CH_OVS = 2;
   localparam int CSS_CH_CP  = 3;
   localparam int CSS_CH_REF = 4;
   localparam int CSS_NCH    = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: MCLK is declared lost after this long without a rising edge
   localparam int CSS_CLK_PERIOD_NS = 25;
   localparam int CSS_MCLK_LOSS_NS  = 1000;
   localparam int CSS_MCLK_LOSS_CYC =
      (CSS_MCLK_LOSS_NS + CSS_CLK_PERIOD_NS - 1) / CSS_CLK_PERIOD_NS;
   localparam logic [7:0] CSS_LOSS_LIMIT = 8'(CSS_MCLK_LOSS_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef struct packed {
      logic pll;
      logic oscillator;
      logic mclk;
      logic sclk;
      logic gpio_zero;
      logic gpio_two;
   } css_src_s;

   typedef struct packed {
      logic       mute;
      logic [2:0] idx;
   } css_sel_s;

endpackage : css_pkg

// file: core/css_clk_mux.sv
// Purpose: One clock-source selector stage with mute.
// Assumes: Candidates are already synchronised to clk.
// Notes:   Output is a flop, so it lags the selection by one cycle.
module css_clk_mux (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [7:0]       cand,
   input  wire css_pkg::css_sel_s sel,
   output logic                  clk_out
);

   wire logic picked;

   assign picked = sel.mute ? 1'b0 : cand[sel.idx];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         clk_out <= 1'b0;
      else
         clk_out <= picked;
   end

endmodule : css_clk_mux

// file: core/css_clock_source_select.sv
// Purpose: Register-driven source selection for DSP, DAC, oversampling,
//          charge-pump dividers and the PLL reference.
// Assumes: Register port is the page-zero control port; one access per cycle.
// Notes:   Source levels are resampled at 40 MHz, so outputs carry jitter of
//          one clk period; fine for control modelling, not for audio use.
module css_clock_source_select (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_we,
   input  wire logic              reg_re,
   output logic [7:0]             reg_rdata,
   input  wire css_pkg::css_src_s src_pins,
   input  wire logic              clock_auto_set,
   input  wire logic              dac_divider_run,
   output logic                   dsp_clock,
   output logic                   dac_clock,
   output logic                   oversampling_clock,
   output logic                   charge_pump_clock,
   output logic                   pll_reference_clock,
   output logic                   master_on_oscillator
);

   ////////////////////////////////////////////////////////////////////////////
   // Decoders
   function automatic css_pkg::css_sel_s dec_core(input logic [2:0] code);
      css_pkg::css_sel_s s;
      s.mute = (code > css_pkg::CSS_CORE_LAST);
      s.idx  = code;
      return s;
   endfunction : dec_core

   function automatic css_pkg::css_sel_s dec_ovs(input logic [2:0] code);
      css_pkg::css_sel_s s;
      s.mute = (code > css_pkg::CSS_OVS_LAST);
      s.idx  = (code == css_pkg::CSS_OVS_DAC) ? css_pkg::CSS_IDX_DAC : code - 3'h1;
      return s;
   endfunction : dec_ovs

   function automatic logic pick_pin(input logic [2:0] code, input logic g0,
                                     input logic g2);
      logic v;
      v = 1'b0;
      if (code == css_pkg::CSS_PIN_ZERO)
         v = g0;
      else if (code == css_pkg::CSS_PIN_TWO)
         v = g2;
      return v;
   endfunction : pick_pin

   ////////////////////////////////////////////////////////////////////////////
   // Source synchroniser and MCLK presence
   css_pkg::css_src_s sync1_reg;
   css_pkg::css_src_s sync2_reg;
   logic              mclk_prev_reg;
   logic [7:0]        loss_cnt_reg;
   logic [7:0]        loss_cnt_next;
   logic              mclk_present;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_reg     <= '0;
         sync2_reg     <= '0;
         mclk_prev_reg <= 1'b0;
         loss_cnt_reg  <= css_pkg::CSS_LOSS_LIMIT;
      end
      else
      begin
         sync1_reg     <= src_pins;
         sync2_reg     <= sync1_reg;
         mclk_prev_reg <= sync2_reg.mclk;
         loss_cnt_reg  <= loss_cnt_next;
      end
   end

   // Saturating count since last MCLK rise; starts "lost" so the oscillator runs first
   assign loss_cnt_next = (sync2_reg.mclk && !mclk_prev_reg) ? 8'h00 :
                          (loss_cnt_reg == css_pkg::CSS_LOSS_LIMIT) ? loss_cnt_reg :
                          loss_cnt_reg + 8'h01;
   assign mclk_present         = (loss_cnt_reg != css_pkg::CSS_LOSS_LIMIT);
   assign master_on_oscillator = !mclk_present;

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   logic [2:0] ref_sel_reg, dsp_src_reg, dac_src_reg, ovs_src_reg, cp_src_reg;
   logic [2:0] dsp_pin_reg, dac_pin_reg, cp_pin_reg, ovs_pin_reg, ref_pin_reg;
   wire  logic wr_ref_dsp, wr_dac_ovs, wr_cp, wr_pin_dd, wr_pin_co, wr_pin_ref;
   wire  logic [2:0] wd_hi, wd_lo;
   logic [7:0] rd_value;

   assign wr_ref_dsp = reg_we && (reg_addr == css_pkg::CSS_OFF_REF_DSP);
   assign wr_dac_ovs = reg_we && (reg_addr == css_pkg::CSS_OFF_DAC_OVS);
   assign wr_cp      = reg_we && (reg_addr == css_pkg::CSS_OFF_CP);
   assign wr_pin_dd  = reg_we && (reg_addr == css_pkg::CSS_OFF_PIN_DD);
   assign wr_pin_co  = reg_we && (reg_addr == css_pkg::CSS_OFF_PIN_CO);
   assign wr_pin_ref = reg_we && (reg_addr == css_pkg::CSS_OFF_PIN_REF);
   assign wd_hi      = reg_wdata[css_pkg::CSS_POS_HI +: 3];
   assign wd_lo      = reg_wdata[css_pkg::CSS_POS_LO +: 3];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ref_sel_reg <= css_pkg::CSS_FIELD_RST;
         dsp_src_reg <= css_pkg::CSS_FIELD_RST;
         dac_src_reg <= css_pkg::CSS_FIELD_RST;
         ovs_src_reg <= css_pkg::CSS_FIELD_RST;
         cp_src_reg  <= css_pkg::CSS_FIELD_RST;
         dsp_pin_reg <= css_pkg::CSS_FIELD_RST;
         dac_pin_reg <= css_pkg::CSS_FIELD_RST;
         cp_pin_reg  <= css_pkg::CSS_FIELD_RST;
         ovs_pin_reg <= css_pkg::CSS_FIELD_RST;
         ref_pin_reg <= css_pkg::CSS_FIELD_RST;
      end
      else
      begin
         if (wr_ref_dsp)
         begin
            ref_sel_reg <= wd_hi;
            dsp_src_reg <= wd_lo;
         end
         if (wr_dac_ovs)
         begin
            dac_src_reg <= wd_hi;
            ovs_src_reg <= wd_lo;
         end
         if (wr_cp)
            cp_src_reg <= wd_lo;
         if (wr_pin_dd)
         begin
            dsp_pin_reg <= wd_hi;
            dac_pin_reg <= wd_lo;
         end
         if (wr_pin_co)
         begin
            cp_pin_reg  <= wd_hi;
            ovs_pin_reg <= wd_lo;
         end
         if (wr_pin_ref)
            ref_pin_reg <= wd_lo;
      end
   end

   // Reserved bits read zero; unmapped addresses read 8'h00
   always_comb
   begin
      if (reg_addr == css_pkg::CSS_OFF_REF_DSP)
         rd_value = {1'b0, ref_sel_reg, 1'b0, dsp_src_reg};
      else if (reg_addr == css_pkg::CSS_OFF_DAC_OVS)
         rd_value = {1'b0, dac_src_reg, 1'b0, ovs_src_reg};
      else if (reg_addr == css_pkg::CSS_OFF_CP)
         rd_value = {5'h00, cp_src_reg};
      else if (reg_addr == css_pkg::CSS_OFF_PIN_DD)
         rd_value = {1'b0, dsp_pin_reg, 1'b0, dac_pin_reg};
      else if (reg_addr == css_pkg::CSS_OFF_PIN_CO)
         rd_value = {1'b0, cp_pin_reg, 1'b0, ovs_pin_reg};
      else if (reg_addr == css_pkg::CSS_OFF_PIN_REF)
         rd_value = {5'h00, ref_pin_reg};
      else
         rd_value = 8'h00;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_re)
         reg_rdata <= rd_value;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Selection
   css_pkg::css_sel_s sel   [css_pkg::CSS_NCH];
   logic [7:0]        cand  [css_pkg::CSS_NCH];
   logic              gpio  [css_pkg::CSS_NCH];
   logic              ch_out[css_pkg::CSS_NCH];
   wire  logic        master_lvl, dac_live;
   css_pkg::css_sel_s dac_raw, ref_sw, ref_auto;

   assign master_lvl = mclk_present ? sync2_reg.pll : sync2_reg.oscillator;
   // Gating with run cuts the derived clocks in the same cycle as the DAC
   assign dac_live   = dac_clock && dac_divider_run;

   assign gpio[css_pkg::CSS_CH_DSP] =
      pick_pin(dsp_pin_reg, sync2_reg.gpio_zero, sync2_reg.gpio_two);
   assign gpio[css_pkg::CSS_CH_DAC] =
      pick_pin(dac_pin_reg, sync2_reg.gpio_zero, sync2_reg.gpio_two);
   assign gpio[css_pkg::CSS_CH_OVS] =
      pick_pin(ovs_pin_reg, sync2_reg.gpio_zero, sync2_reg.gpio_two);
   assign gpio[css_pkg::CSS_CH_CP]  =
      pick_pin(cp_pin_reg, sync2_reg.gpio_zero, sync2_reg.gpio_two);
   assign gpio[css_pkg::CSS_CH_REF] =
      pick_pin(ref_pin_reg, sync2_reg.gpio_zero, sync2_reg.gpio_two);

   assign sel[css_pkg::CSS_CH_DSP] = dec_core(dsp_src_reg);
   assign dac_raw                  = dec_core(dac_src_reg);
   assign sel[css_pkg::CSS_CH_DAC] = '{mute: dac_raw.mute || !dac_divider_run,
                                       idx: dac_raw.idx};
   assign sel[css_pkg::CSS_CH_OVS] = dec_ovs(ovs_src_reg);
   assign sel[css_pkg::CSS_CH_CP]  = dec_ovs(cp_src_reg);

   // Reference codes map onto the shared candidate positions
   assign ref_sw.mute = (ref_sel_reg > css_pkg::CSS_REF_GPIO);
   assign ref_sw.idx  = (ref_sel_reg == css_pkg::CSS_REF_MCLK) ? css_pkg::CSS_IDX_MCLK :
                        (ref_sel_reg == css_pkg::CSS_REF_SCLK) ? css_pkg::CSS_IDX_SCLK :
                        (ref_sel_reg == css_pkg::CSS_REF_OSCILLATOR) ?
                        css_pkg::CSS_IDX_OSCILLATOR :
                        css_pkg::CSS_IDX_GPIO;
   // Auto mode: MCLK while it toggles, otherwise fall back to SCLK
   assign ref_auto.mute = 1'b0;
   assign ref_auto.idx  = mclk_present ? css_pkg::CSS_IDX_MCLK : css_pkg::CSS_IDX_SCLK;
   assign sel[css_pkg::CSS_CH_REF] = clock_auto_set ? ref_auto : ref_sw;

   genvar ch;
   generate
      for (ch = 0; ch < css_pkg::CSS_NCH; ch++)
      begin : g_ch
         assign cand[ch] = {1'b0, dac_live, gpio[ch], sync2_reg.sclk, sync2_reg.mclk,
                            sync2_reg.oscillator, sync2_reg.pll, master_lvl};
         css_clk_mux u_mux (
            .clk     (clk),
            .rst     (rst),
            .cand    (cand[ch]),
            .sel     (sel[ch]),
            .clk_out (ch_out[ch])
         );
      end
   endgenerate

   assign dsp_clock           = ch_out[css_pkg::CSS_CH_DSP];
   assign dac_clock           = ch_out[css_pkg::CSS_CH_DAC];
   assign oversampling_clock  = ch_out[css_pkg::CSS_CH_OVS];
   assign charge_pump_clock   = ch_out[css_pkg::CSS_CH_CP];
   assign pll_reference_clock = ch_out[css_pkg::CSS_CH_REF];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   ref_mclk_path_a: assert property (!clock_auto_set && ref_sel_reg == 3'h0
      |=> pll_reference_clock == $past(sync2_reg.mclk)) else $error("ref not MCLK");
   ref_auto_pick_a: assert property (clock_auto_set
      |=> pll_reference_clock == $past(mclk_present ? sync2_reg.mclk : sync2_reg.sclk))
      else $error("auto reference wrong");
   ref_mute_a: assert property (!clock_auto_set && ref_sel_reg > 3'h3
      |=> !pll_reference_clock) else $error("reserved reference not muted");
   dsp_mute_a: assert property (dsp_src_reg > 3'h5 ##1 dsp_src_reg > 3'h5
      |=> !dsp_clock [*1]) else $error("reserved dsp code not muted");
   dac_pll_path_a: assert property (dac_divider_run && dac_src_reg == 3'h1
      |=> dac_clock == $past(sync2_reg.pll)) else $error("dac not on pll");
   ovs_dac_path_a: assert property (ovs_src_reg == 3'h0
      |=> oversampling_clock == $past(dac_clock && dac_divider_run))
      else $error("oversampling not on dac");
   cp_mute_a: assert property (cp_src_reg == 3'h7 |=> !charge_pump_clock)
      else $error("reserved cp code not muted");
   master_pick_a: assert property (dsp_src_reg == 3'h0
      |=> dsp_clock == $past(mclk_present ? sync2_reg.pll : sync2_reg.oscillator))
      else $error("master clock pick wrong");
   dsp_pin_two_a: assert property (dsp_src_reg == 3'h5 && dsp_pin_reg == 3'h5
      |=> dsp_clock == $past(sync2_reg.gpio_two)) else $error("dsp pin two wrong");
   dac_pin_mute_a: assert property (dac_src_reg == 3'h5 && dac_pin_reg == 3'h2
      |=> !dac_clock) else $error("dac pin not muted");
   cp_pin_mute_a: assert property (cp_src_reg == 3'h6 && cp_pin_reg == 3'h2
      |=> !charge_pump_clock) else $error("cp pin 010 not muted");
   ovs_pin_zero_a: assert property (ovs_src_reg == 3'h6 && ovs_pin_reg == 3'h3
      |=> oversampling_clock == $past(sync2_reg.gpio_zero)) else $error("ovs pin zero");
   reset_fields_a: assert property ($fell(rst) |-> ref_sel_reg == 3'h0
      && dsp_src_reg == 3'h0 && dac_src_reg == 3'h0 && ovs_src_reg == 3'h0
      && cp_src_reg == 3'h0) else $error("fields not zero after reset");
   dac_halt_a: assert property (!dac_divider_run
      |=> !dac_clock && (ovs_src_reg != 3'h0 || !oversampling_clock))
      else $error("dac clock not halted");
   ref_pin_zero_a: assert property (!clock_auto_set && ref_sel_reg == 3'h3
      && ref_pin_reg == 3'h3 |=> pll_reference_clock == $past(sync2_reg.gpio_zero))
      else $error("reference pin zero wrong");

endmodule : css_clock_source_select

// file: verification/css_tb.sv
// Purpose: Self-checking bench for the clock source select block.
// Assumes: Sources are static levels except the MCLK presence test.
// Notes:   Every select code is swept against every one-hot source pattern.
module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk;
   logic              rst;
   logic [7:0]        reg_addr;
   logic [7:0]        reg_wdata;
   logic              reg_we;
   logic              reg_re;
   logic [7:0]        reg_rdata;
   css_pkg::css_src_s src_pins;
   logic              clock_auto_set;
   logic              dac_divider_run;
   logic              dsp_clock;
   logic              dac_clock;
   logic              oversampling_clock;
   logic              charge_pump_clock;
   logic              pll_reference_clock;
   logic              master_on_oscillator;
   logic              mclk_live;
   logic [2:0]        pin_cur;
   logic [7:0]        rd_data;
   int                num_errors;
   int                samples_checked;
   logic [7:0]        offs [7] = '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13};
   logic [7:0]        mask [7] = '{8'h77, 8'h77, 8'h07, 8'h77, 8'h77, 8'h07, 8'h00};

   css_clock_source_select DUT (
      .clk                  (clk),
      .rst                  (rst),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_we               (reg_we),
      .reg_re               (reg_re),
      .reg_rdata            (reg_rdata),
      .src_pins             (src_pins),
      .clock_auto_set       (clock_auto_set),
      .dac_divider_run      (dac_divider_run),
      .dsp_clock            (dsp_clock),
      .dac_clock            (dac_clock),
      .oversampling_clock   (oversampling_clock),
      .charge_pump_clock    (charge_pump_clock),
      .pll_reference_clock  (pll_reference_clock),
      .master_on_oscillator (master_on_oscillator)
   );

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic pin_src(input logic [2:0] p, input css_pkg::css_src_s s);
      return (p == 3'h3) ? s.gpio_zero : ((p == 3'h5) ? s.gpio_two : 1'b0);
   endfunction : pin_src

   // Master clock falls back to the oscillator while MCLK is absent
   function automatic logic core_src(input logic [2:0] c, input logic [2:0] p,
                                     input css_pkg::css_src_s s, input logic live);
      case (c)
         3'h0: return live ? s.pll : s.oscillator;
         3'h1: return s.pll;
         3'h2: return s.oscillator;
         3'h3: return s.mclk;
         3'h4: return s.sclk;
         3'h5: return pin_src(p, s);
         default: return 1'b0;
      endcase
   endfunction : core_src

   function automatic logic ref_src(input logic [2:0] c, input logic [2:0] p,
                                    input css_pkg::css_src_s s, input logic aut,
                                    input logic live);
      if (aut)
         return live ? s.mclk : s.sclk;
      case (c)
         3'h0: return s.mclk;
         3'h1: return s.sclk;
         3'h2: return s.oscillator;
         3'h3: return pin_src(p, s);
         default: return 1'b0;
      endcase
   endfunction : ref_src

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_we    = 1'b1;
      @(negedge clk);
      reg_we = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_re   = 1'b1;
      @(negedge clk);
      reg_re = 1'b0;
      d      = reg_rdata;
   endtask : rd

   task automatic check_outs(input logic [2:0] c);
      logic dsp_e;
      logic dac_e;
      logic ovs_e;
      logic ref_e;
      dsp_e = core_src(c, pin_cur, src_pins, mclk_live);
      dac_e = dsp_e & dac_divider_run;
      // Oversampling code n maps onto core code n-1, code 0 follows the DAC clock
      ovs_e = (c == 3'h0) ? dac_e : core_src(c - 3'h1, pin_cur, src_pins, mclk_live);
      ref_e = ref_src(c, pin_cur, src_pins, clock_auto_set, mclk_live);
      check("dsp", {7'h00, dsp_e}, {7'h00, dsp_clock});
      check("dac", {7'h00, dac_e}, {7'h00, dac_clock});
      check("ovs", {7'h00, ovs_e}, {7'h00, oversampling_clock});
      check("cp", {7'h00, ovs_e}, {7'h00, charge_pump_clock});
      check("ref", {7'h00, ref_e}, {7'h00, pll_reference_clock});
      check("master_fallback", {7'h00, ~mclk_live}, {7'h00, master_on_oscillator});
   endtask : check_outs

   // Same code in every source field, so one sweep covers all five channels
   task automatic apply(input logic [2:0] c, input logic [5:0] s);
      src_pins = css_pkg::css_src_s'(s);
      wr(8'h0D, {1'b0, c, 1'b0, c});
      wr(8'h0E, {1'b0, c, 1'b0, c});
      wr(8'h0F, {5'h00, c});
      repeat (6) @(negedge clk);
      check_outs(c);
   endtask : apply

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(40000 * 25);
      num_errors++;
      close_out();
   end

   initial
   begin
      rst = 1'b1;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_we = 1'b0;
      reg_re = 1'b0;
      src_pins = '0;
      clock_auto_set = 1'b0;
      dac_divider_run = 1'b1;
      mclk_live = 1'b0;
      pin_cur = 3'h0;
      num_errors = 0;
      samples_checked = 0;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 7; i++)
      begin
         rd(offs[i], rd_data);
         check("reset_read", 8'h00, rd_data);
      end
      // Reserved bits and the unmapped offset must not hold written ones
      for (int i = 0; i < 7; i++)
      begin
         wr(offs[i], 8'hFF);
         rd(offs[i], rd_data);
         check("readback", mask[i], rd_data);
      end
      for (int p = 0; p < 8; p++)
      begin
         pin_cur = 3'(p);
         wr(8'h10, {1'b0, pin_cur, 1'b0, pin_cur});
         wr(8'h11, {1'b0, pin_cur, 1'b0, pin_cur});
         wr(8'h12, {5'h00, pin_cur});
         for (int s = 0; s < 6; s++)
         begin
            // A fresh MCLK rise makes it present for a while; let that lapse so
            // the sweep sees the oscillator fallback throughout
            src_pins = css_pkg::css_src_s'(6'h20 >> s);
            repeat (60) @(negedge clk);
            for (int c = 0; c < 8; c++)
               apply(3'(c), 6'h20 >> s);
         end
      end
      dac_divider_run = 1'b0;
      apply(3'h0, 6'h10);
      apply(3'h5, 6'h01);
      dac_divider_run = 1'b1;
      clock_auto_set = 1'b1;
      apply(3'h2, 6'h04);
      apply(3'h2, 6'h10);
      clock_auto_set = 1'b0;
      apply(3'h0, 6'h20);
      repeat (12)
      begin
         repeat (4) @(negedge clk);
         src_pins.mclk = ~src_pins.mclk;
      end
      check("master_fallback", 8'h00, {7'h00, master_on_oscillator});
      check("dsp_pll", 8'h01, {7'h00, dsp_clock});
      repeat (60) @(negedge clk);
      check("master_fallback", 8'h01, {7'h00, master_on_oscillator});
      check("dsp_oscillator", 8'h00, {7'h00, dsp_clock});
      close_out();
   end

endmodule : tb
